//--- llb_core.v
// Legacy link bring-up register file, immunity control and sideband forwarding
//
// Notes on behaviour
// - Legacy link waits for serializer pixel clock
// - Immunity from straps at power-up or bit 7
// - High bandwidth enable; CRC errors clear on read
// - Forwarded input on by default, not with sync
// - Forwarded input wins; hold I2C, drop UART
// - Control pin availability follows width, bandwidth
`timescale 1ns/1ps
`include "llb_defs.vh"
module llb_core (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        clk_en,
  input  wire        cfg_immunity_strap,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        serializer_pclk_present,
  input  wire        multifunction_pin_one,
  input  wire        crc_error_event,
  input  wire        i2c_request,
  input  wire        uart_request,
  input  wire        video_blanking,
  input  wire [4:0]  forward_control_pin_in,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  output reg         reg_err,
  output reg         high_immunity_mode,
  output reg         forward_link_up,
  output reg         forwarded_output,
  output reg         forwarded_input_send,
  output reg         i2c_stretch,
  output reg         uart_overwritten,
  output reg         forward_tx_enable,
  output reg         local_ack_enable,
  output reg         packet_control_enable,
  output reg         no_remote_host,
  output reg         csi_output_enable,
  output wire [4:0]  forward_control_pin,
  output wire [4:0]  forward_control_avail
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [7:0] link_mode_select;
  reg [7:0] csi_output_control;
  reg [7:0] forward_control_transmit;
  reg [7:0] remote_host_control;
  reg [7:0] immunity_control;
  reg [7:0] width_bandwidth_control;
  reg [7:0] packet_control_config;
  reg [7:0] local_ack_control;
  reg [7:0] sync_enable_control;
  reg [7:0] control_crc_errors;
  reg [7:0] video_datatype_select;
  reg [7:0] sync_shift_control;
  reg [7:0] reverse_tx_amplitude;
  reg [7:0] reverse_edge_time;
  reg [7:0] reverse_pulse_length;
  reg       strap_taken;
  reg       fwd_in_last;

  // Address decode shared by read and write
  function is_mapped;
    input [15:0] a;
    begin
      case (a)
        `LLB_ADDR_LINK_MODE, `LLB_ADDR_CSI_OUT, `LLB_ADDR_FWD_CTRL_TX,
        `LLB_ADDR_REMOTE_HOST, `LLB_ADDR_IMMUNITY, `LLB_ADDR_WIDTH_BW,
        `LLB_ADDR_PKT_CFG, `LLB_ADDR_LOCAL_ACK, `LLB_ADDR_SYNC_EN,
        `LLB_ADDR_CRC_ERR, `LLB_ADDR_VID_DT, `LLB_ADDR_SYNC_SHIFT,
        `LLB_ADDR_REV_AMP, `LLB_ADDR_REV_EDGE, `LLB_ADDR_REV_PULSE: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    case (reg_addr)
      `LLB_ADDR_LINK_MODE:   rd_mux = link_mode_select;
      `LLB_ADDR_CSI_OUT:     rd_mux = csi_output_control;
      `LLB_ADDR_FWD_CTRL_TX: rd_mux = forward_control_transmit;
      `LLB_ADDR_REMOTE_HOST: rd_mux = remote_host_control;
      `LLB_ADDR_IMMUNITY:    rd_mux = immunity_control;
      `LLB_ADDR_WIDTH_BW:    rd_mux = width_bandwidth_control;
      `LLB_ADDR_PKT_CFG:     rd_mux = packet_control_config;
      `LLB_ADDR_LOCAL_ACK:   rd_mux = local_ack_control;
      `LLB_ADDR_SYNC_EN:     rd_mux = sync_enable_control;
      `LLB_ADDR_CRC_ERR:     rd_mux = control_crc_errors;
      `LLB_ADDR_VID_DT:      rd_mux = video_datatype_select;
      `LLB_ADDR_SYNC_SHIFT:  rd_mux = sync_shift_control;
      `LLB_ADDR_REV_AMP:     rd_mux = reverse_tx_amplitude;
      `LLB_ADDR_REV_EDGE:    rd_mux = reverse_edge_time;
      `LLB_ADDR_REV_PULSE:   rd_mux = reverse_pulse_length;
      default:               rd_mux = 8'h00;
    endcase
  end

  wire wr_hit = reg_wr && is_mapped(reg_addr);
  wire crc_rd = reg_rd && (reg_addr == `LLB_ADDR_CRC_ERR);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      link_mode_select         <= `LLB_RST_LINK_MODE;
      csi_output_control       <= `LLB_RST_CSI_OUT;
      forward_control_transmit <= `LLB_RST_FWD_CTRL_TX;
      remote_host_control      <= `LLB_RST_REMOTE_HOST;
      width_bandwidth_control  <= `LLB_RST_WIDTH_BW;
      packet_control_config    <= `LLB_RST_PKT_CFG;
      local_ack_control        <= `LLB_RST_LOCAL_ACK;
      sync_enable_control      <= `LLB_RST_SYNC_EN;
      video_datatype_select    <= `LLB_RST_VID_DT;
      sync_shift_control       <= `LLB_RST_SYNC_SHIFT;
      reverse_tx_amplitude     <= `LLB_RST_REV_AMP;
      reverse_edge_time        <= `LLB_RST_REV_EDGE;
      reverse_pulse_length     <= `LLB_RST_REV_PULSE;
    end else if (clk_en) begin
      if (wr_hit) begin
        case (reg_addr)
          `LLB_ADDR_LINK_MODE:   link_mode_select         <= reg_wdata;
          `LLB_ADDR_CSI_OUT:     csi_output_control       <= reg_wdata;
          `LLB_ADDR_FWD_CTRL_TX: forward_control_transmit <= reg_wdata;
          `LLB_ADDR_REMOTE_HOST: remote_host_control      <= reg_wdata;
          `LLB_ADDR_WIDTH_BW:    width_bandwidth_control  <= reg_wdata;
          `LLB_ADDR_PKT_CFG:     packet_control_config    <= reg_wdata;
          `LLB_ADDR_LOCAL_ACK:   local_ack_control        <= reg_wdata;
          `LLB_ADDR_SYNC_EN:     sync_enable_control      <= reg_wdata;
          `LLB_ADDR_VID_DT:      video_datatype_select    <= reg_wdata;
          `LLB_ADDR_SYNC_SHIFT:  sync_shift_control       <= reg_wdata;
          `LLB_ADDR_REV_AMP:     reverse_tx_amplitude     <= reg_wdata;
          `LLB_ADDR_REV_EDGE:    reverse_edge_time        <= reg_wdata;
          `LLB_ADDR_REV_PULSE:   reverse_pulse_length     <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Immunity register, strap and host write
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      immunity_control <= `LLB_RST_IMMUNITY;
      strap_taken      <= 1'b0;
    end else if (clk_en) begin
      // Strap caught once after reset release; a host write in that edge wins
      if (!strap_taken) begin
        strap_taken <= 1'b1;
        if (cfg_immunity_strap)
          immunity_control[`LLB_BIT_IMMUNITY_EN] <= 1'b1;
      end
      if (wr_hit && reg_addr == `LLB_ADDR_IMMUNITY)
        immunity_control <= reg_wdata;
    end
  end

  // ----------------------------------------
  // CRC error count, clear on read
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      control_crc_errors <= 8'h00;
    end else if (clk_en) begin
      // A new error in the reading cycle survives the clear
      if (crc_rd)
        control_crc_errors <= {7'h00, crc_error_event};
      else if (crc_error_event && control_crc_errors != 8'hff)
        control_crc_errors <= control_crc_errors + 8'h01;
    end
  end

  // ----------------------------------------
  // Read answer
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      reg_rdata  <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Unmapped access flag
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_err <= 1'b0;
    end else if (clk_en) begin
      reg_err <= (reg_rd || reg_wr) && !is_mapped(reg_addr);
    end
  end

  // ----------------------------------------
  // Link state and sideband forwarding
  // ----------------------------------------
  wire legacy_mode   = link_mode_select[`LLB_BIT_LEGACY_MODE];
  wire frame_sync_on = sync_enable_control[`LLB_BIT_FRAME_SYNC_EN];
  wire fwd_in_enable = packet_control_config[`LLB_BIT_FWD_INPUT_EN] && !frame_sync_on;
  wire fwd_in_change = fwd_in_enable && (multifunction_pin_one != fwd_in_last);

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      high_immunity_mode <= 1'b0;
      forward_link_up    <= 1'b0;
    end else if (clk_en) begin
      high_immunity_mode <= immunity_control[`LLB_BIT_IMMUNITY_EN];
      // Legacy link forms only with pixel clock at the serializer
      forward_link_up    <= legacy_mode && serializer_pclk_present;
    end
  end

  // ----------------------------------------
  // Forwarded input toward the remote side
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      forwarded_output     <= 1'b0;
      forwarded_input_send <= 1'b0;
      i2c_stretch          <= 1'b0;
      uart_overwritten     <= 1'b0;
      fwd_in_last          <= 1'b0;
    end else if (clk_en) begin
      fwd_in_last          <= multifunction_pin_one;
      forwarded_input_send <= fwd_in_change;
      if (fwd_in_change)
        forwarded_output   <= multifunction_pin_one;
      // Forwarded input wins: I2C is stretched, a UART frame is lost
      i2c_stretch          <= fwd_in_change && i2c_request;
      uart_overwritten     <= fwd_in_change && uart_request;
    end
  end

  // ----------------------------------------
  // Register mirrors
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      forward_tx_enable     <= 1'b0;
      local_ack_enable      <= 1'b0;
      packet_control_enable <= 1'b0;
      no_remote_host        <= 1'b0;
      csi_output_enable     <= 1'b0;
    end else if (clk_en) begin
      // Mirrors lag their register by one cycle
      forward_tx_enable     <= forward_control_transmit[`LLB_BIT_FWD_TX_EN];
      local_ack_enable      <= local_ack_control[`LLB_BIT_LOCAL_ACK];
      packet_control_enable <= packet_control_config[`LLB_BIT_PKT_CTRL_EN];
      no_remote_host        <= remote_host_control[`LLB_BIT_NO_REMOTE_HOST];
      csi_output_enable     <= csi_output_control[`LLB_BIT_CSI_OUT_EN];
    end
  end

  // ----------------------------------------
  // Forward control pins
  // ----------------------------------------
  llb_forward_control_pin_map u_forward_control_pin_map (
    .core_clk              (core_clk),
    .nrst                  (nrst),
    .clk_en                (clk_en),
    .bus_width_select      (width_bandwidth_control[`LLB_BIT_BUS_WIDTH]),
    .high_bandwidth_mode   (width_bandwidth_control[`LLB_BIT_HIGH_BW]),
    .blanking              (video_blanking),
    .forward_control_pin_in               (forward_control_pin_in),
    .forward_control_pin   (forward_control_pin),
    .forward_control_avail (forward_control_avail)
  );

endmodule

//--- llb_defs.vh
// Register map, field positions and reset values of the legacy link bring-up block
`ifndef LLB_DEFS_VH
`define LLB_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LLB_ADDR_LINK_MODE      16'h0006
`define LLB_ADDR_CSI_OUT        16'h0313
`define LLB_ADDR_FWD_CTRL_TX    16'h0b04
`define LLB_ADDR_REMOTE_HOST    16'h0b05
`define LLB_ADDR_IMMUNITY       16'h0b06
`define LLB_ADDR_WIDTH_BW       16'h0b07
`define LLB_ADDR_PKT_CFG        16'h0b08
`define LLB_ADDR_LOCAL_ACK      16'h0b0d
`define LLB_ADDR_SYNC_EN        16'h0b0f
`define LLB_ADDR_CRC_ERR        16'h0b19
`define LLB_ADDR_VID_DT         16'h0b96
`define LLB_ADDR_SYNC_SHIFT     16'h0ba7
`define LLB_ADDR_REV_AMP        16'h1495
`define LLB_ADDR_REV_EDGE       16'h14c4
`define LLB_ADDR_REV_PULSE      16'h14c5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LLB_BIT_IMMUNITY_EN     7
`define LLB_BIT_HIGH_BW         3
`define LLB_BIT_BUS_WIDTH       2
`define LLB_BIT_FWD_INPUT_EN    4
`define LLB_BIT_PKT_CTRL_EN     5
`define LLB_BIT_LEGACY_MODE     6
`define LLB_BIT_FRAME_SYNC_EN   0
`define LLB_BIT_FWD_TX_EN       0
`define LLB_BIT_LOCAL_ACK       7
`define LLB_BIT_NO_REMOTE_HOST  0
`define LLB_BIT_CSI_OUT_EN      1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LLB_RST_LINK_MODE       8'h00
`define LLB_RST_CSI_OUT         8'h02
`define LLB_RST_FWD_CTRL_TX     8'h03
`define LLB_RST_REMOTE_HOST     8'h00
`define LLB_RST_IMMUNITY        8'h6f
`define LLB_RST_WIDTH_BW        8'h00
`define LLB_RST_PKT_CFG         8'h10
`define LLB_RST_LOCAL_ACK       8'h00
`define LLB_RST_SYNC_EN         8'h00
`define LLB_RST_VID_DT          8'h00
`define LLB_RST_SYNC_SHIFT      8'h00
`define LLB_RST_REV_AMP         8'h69
`define LLB_RST_REV_EDGE        8'h40
`define LLB_RST_REV_PULSE       8'h40

`endif

//--- llb_forward_control_pin_map.v
// Forward control pin availability by width and bandwidth mode
`timescale 1ns/1ps
module llb_forward_control_pin_map (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       clk_en,
  input  wire       bus_width_select,
  input  wire       high_bandwidth_mode,
  input  wire       blanking,
  input  wire [4:0] forward_control_pin_in,
  output reg  [4:0] forward_control_pin,
  output reg  [4:0] forward_control_avail
);

  // ----------------------------------------
  // Availability per pin
  // ----------------------------------------
  reg [4:0] full_mask;
  reg [4:0] blank_mask;
  reg [4:0] next_pin;

  always @* begin
    full_mask  = 5'h00;
    blank_mask = 5'h00;
    if (bus_width_select) begin
      full_mask = 5'h16;
    end else if (high_bandwidth_mode) begin
      blank_mask = 5'h0f;
    end else begin
      full_mask = 5'h10;
    end
    // Unavailable pins hold; blanking-only pins move only in blanking
    next_pin = (forward_control_pin & ~full_mask) | (forward_control_pin_in & full_mask);
    if (blanking) begin
      next_pin = (next_pin & ~blank_mask) | (forward_control_pin_in & blank_mask);
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      forward_control_pin   <= 5'h00;
      forward_control_avail <= 5'h00;
    end else if (clk_en) begin
      forward_control_pin   <= next_pin;
      forward_control_avail <= full_mask | blank_mask;
    end
  end

endmodule

//--- llb_core_chk.sv
// Port checker of the legacy link bring-up core
`timescale 1ns/1ps
`include "llb_defs.vh"
module llb_core_chk (
  input wire        core_clk,
  input wire        nrst,
  input wire        clk_en,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        serializer_pclk_present,
  input wire        crc_error_event,
  input wire        i2c_request,
  input wire        uart_request,
  input wire        video_blanking,
  input wire [4:0]  forward_control_pin_in,
  input wire [7:0]  reg_rdata,
  input wire        high_immunity_mode,
  input wire        forward_link_up,
  input wire        forwarded_input_send,
  input wire        i2c_stretch,
  input wire        uart_overwritten,
  input wire [4:0]  forward_control_pin,
  input wire [4:0]  forward_control_avail
);
  // ----------------------------------------
  // Shadow of mode and forwarding enables
  // ----------------------------------------
  logic [7:0] mode_q;
  logic [1:0] age;
  logic       en_q;
  logic       fs_q;
  wire        wr      = reg_wr & clk_en;
  wire        bw      = mode_q[`LLB_BIT_BUS_WIDTH];
  wire        hb      = mode_q[`LLB_BIT_HIGH_BW];
  wire        fwd_ok  = en_q & ~fs_q;
  wire        imm_bit = reg_wdata[`LLB_BIT_IMMUNITY_EN];
  wire        fixed   = age == 2'h3 && !(hb && !bw);
  wire        crc_rd  = reg_rd && clk_en && reg_addr == `LLB_ADDR_CRC_ERR && !crc_error_event;
  wire  [4:0] full    = bw ? 5'h16 : 5'h10;
  wire  [4:0] held    = forward_control_pin & ~full;
  wire  [4:0] pin_f   = forward_control_pin & full;
  wire  [4:0] in_f    = forward_control_pin_in & full;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= 8'h00;
      age    <= 2'h0;
      en_q   <= 1'b1;
      fs_q   <= 1'b0;
    end else if (clk_en) begin
      age <= (wr && reg_addr == `LLB_ADDR_WIDTH_BW) ? 2'h0 : ((age == 2'h3) ? age : age + 2'h1);
      if (wr && reg_addr == `LLB_ADDR_WIDTH_BW) mode_q <= reg_wdata;
      if (wr && reg_addr == `LLB_ADDR_PKT_CFG) en_q <= reg_wdata[`LLB_BIT_FWD_INPUT_EN];
      if (wr && reg_addr == `LLB_ADDR_SYNC_EN) fs_q <= reg_wdata[`LLB_BIT_FRAME_SYNC_EN];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_imm; (wr && reg_addr == `LLB_ADDR_IMMUNITY) ##1 clk_en |=> high_immunity_mode == $past(imm_bit, 2);
  endproperty
  a_imm: assert property (p_imm) else $error("immunity mode differs from written bit");
  property p_crc; crc_rd ##1 crc_rd |=> reg_rdata == 8'h00; endproperty
  a_crc: assert property (p_crc) else $error("error count not cleared by read");
  property p_link; forward_link_up && $past(clk_en) |-> $past(serializer_pclk_present); endproperty
  a_link: assert property (p_link) else $error("link up without pixel clock");
  property p_fwd_off; !$past(fwd_ok) |-> !forwarded_input_send; endproperty
  a_fwd_off: assert property (p_fwd_off) else $error("forwarding while disabled");
  property p_i2c; i2c_stretch == (forwarded_input_send && $past(i2c_request)); endproperty
  a_i2c: assert property (p_i2c) else $error("stretch not tied to forwarding");
  property p_uart; uart_overwritten == (forwarded_input_send && $past(uart_request)); endproperty
  a_uart: assert property (p_uart) else $error("overwrite not tied to forwarding");
  property p_avail; fixed |-> forward_control_avail == full; endproperty
  a_avail: assert property (p_avail) else $error("control pin availability wrong");
  property p_follow;
    fixed && $past(clk_en) |-> pin_f == $past(in_f) && held == ($past(forward_control_pin) & ~full);
  endproperty
  a_follow: assert property (p_follow) else $error("control pins do not follow mode");
  property p_blank; age == 2'h3 && hb && !bw && !$past(video_blanking) |-> $stable(forward_control_pin);
  endproperty
  a_blank: assert property (p_blank) else $error("control pins moved outside blanking");
endmodule
bind llb_core llb_core_chk u_chk (.*);

//--- llb_ser_model.sv
// Remote serializer model: pixel clock, forwarded input, control pins
`timescale 1ns/1ps
module llb_ser_model #(
  parameter int PCLK_DELAY = 6
) (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        ser_wr,
  input  wire  [7:0] ser_addr,
  input  wire  [7:0] ser_data,
  input  wire        gpi_level,
  output logic       serializer_pclk_present,
  output logic       multifunction_pin_one,
  output logic       video_blanking,
  output logic [4:0] forward_control_pin_in
);
  logic [7:0] link_reg;
  int         pclk_cnt;
  assign multifunction_pin_one = gpi_level;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      link_reg <= 8'h00;
      pclk_cnt <= 0;
      forward_control_pin_in <= 5'h00;
      video_blanking <= 1'b0;
      serializer_pclk_present <= 1'b0;
    end else begin
      if (ser_wr && ser_addr == 8'h04) link_reg <= ser_data;
      pclk_cnt <= link_reg[7] ? pclk_cnt + 1 : 0;
      serializer_pclk_present <= link_reg[7] && pclk_cnt >= PCLK_DELAY;
      forward_control_pin_in <= forward_control_pin_in + 5'h03;
      video_blanking <= forward_control_pin_in[2];
    end
  end
endmodule

//--- llb_core_tb.sv
// Self-checking testbench of the legacy link bring-up core
`timescale 1ns/1ps
`include "llb_defs.vh"
module llb_core_tb;
  localparam int MS = 20;
  localparam logic [23:0] RST [15] = '{24'h000600, 24'h031302, 24'h0b0403, 24'h0b0500, 24'h0b066f, 24'h0b0700,
    24'h0b0810, 24'h0b0d00, 24'h0b0f00, 24'h0b1900, 24'h0b9600, 24'h0ba700, 24'h149569, 24'h14c440, 24'h14c540};
  localparam logic [35:0] SEQ [18] = '{36'h0_0006_40_05, 36'h0_0313_00_00, 36'h0_0b0d_81_00, 36'h1_004d_40_0a,
    36'h0_0b06_6f_00, 36'h0_14c5_aa_00, 36'h0_14c4_80_00, 36'h0_1495_c8_00, 36'h1_0004_43_05, 36'h0_0b04_02_00,
    36'h1_004d_c0_05, 36'h0_0b06_ef_00, 36'h0_14c5_40_00, 36'h0_14c4_40_00, 36'h0_1495_69_00, 36'h0_0b04_03_00,
    36'h0_0b0d_00_00, 36'h0_0b08_25_0a};
  logic        core_clk, nrst, clk_en, cfg_immunity_strap, reg_wr, reg_rd, crc_error_event;
  logic        i2c_request, uart_request, ser_wr, gpi_level, fo;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, ser_addr, ser_data;
  wire  [7:0]  reg_rdata;
  wire  [4:0]  forward_control_pin_in, forward_control_pin, forward_control_avail;
  wire         serializer_pclk_present, multifunction_pin_one, video_blanking, reg_rvalid, reg_err;
  wire         high_immunity_mode, forward_link_up, forwarded_output, forwarded_input_send, i2c_stretch;
  wire         uart_overwritten, forward_tx_enable, local_ack_enable, packet_control_enable;
  wire         no_remote_host, csi_output_enable;
  int          fails, n_compared;
  llb_core u_llb_core (.*);
  llb_ser_model u_llb_ser_model (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    ser_wr <= 1'b1;
    ser_addr <= a;
    ser_data <= d;
    @(posedge core_clk);
    ser_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rvalid", {7'h0, reg_rvalid}, 8'h01);
    chk("reg_rdata", reg_rdata, exp);
  endtask
  task automatic forwarded_input(input logic v, input logic e, input logic q, input logic u);
    @(posedge core_clk);
    gpi_level <= v;
    i2c_request <= q;
    uart_request <= u;
    @(posedge core_clk);
    if (e) fo = v;
    #1 chk("forwarding", {4'h0, forwarded_input_send, i2c_stretch, uart_overwritten, forwarded_output},
           {4'h0, e, e & q, e & u, fo});
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    test_done;
  end
  initial begin
    {nrst, cfg_immunity_strap, reg_wr, reg_rd, crc_error_event, i2c_request, uart_request, ser_wr, gpi_level} = '0;
    {reg_addr, reg_wdata, ser_addr, ser_data, fo} = '0;
    clk_en = 1'b1;
    fails = 0;
    n_compared = 0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk("reset outputs", {high_immunity_mode, forward_link_up, forward_tx_enable, local_ack_enable}, 8'h02);
    // Write while frozen must not land; the reset value is read back below
    clk_en <= 1'b0;
    wr(`LLB_ADDR_REV_AMP, 8'h11);
    clk_en <= 1'b1;
    foreach (RST[i]) rd(RST[i][23:8], RST[i][7:0]);
    rd(16'h2000, 8'h00);
    chk("reg_err", {7'h0, reg_err}, 8'h01);
    foreach (SEQ[i]) begin
      if (SEQ[i][32]) sw(SEQ[i][23:16], SEQ[i][15:8]);
      else wr(SEQ[i][31:16], SEQ[i][15:8]);
      if (!SEQ[i][32]) rd(SEQ[i][31:16], SEQ[i][15:8]);
      repeat (SEQ[i][7:0] * MS) @(posedge core_clk);
    end
    wr(`LLB_ADDR_REMOTE_HOST, 8'h79);
    #1 chk("forward_link_up", {7'h0, forward_link_up}, 8'h00);
    sw(8'h04, 8'h83);
    repeat (12) @(posedge core_clk);
    #1 chk("mirrors", {forward_tx_enable, local_ack_enable, packet_control_enable, no_remote_host,
           csi_output_enable, high_immunity_mode, forward_link_up}, 8'h5b);
    wr(`LLB_ADDR_WIDTH_BW, 8'h08);
    repeat (3) begin
      @(posedge core_clk);
      crc_error_event <= 1'b1;
      @(posedge core_clk);
      crc_error_event <= 1'b0;
    end
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= `LLB_ADDR_CRC_ERR;
    @(posedge core_clk);
    #1 chk("crc count", reg_rdata, 8'h03);
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("crc cleared", reg_rdata, 8'h00);
    chk("avail blank", {3'h0, forward_control_avail}, 8'h0f);
    wr(`LLB_ADDR_WIDTH_BW, 8'h04);
    repeat (6) @(posedge core_clk);
    #1 chk("avail wide", {3'h0, forward_control_avail}, 8'h16);
    wr(`LLB_ADDR_WIDTH_BW, 8'h00);
    repeat (6) @(posedge core_clk);
    #1 chk("avail narrow", {3'h0, forward_control_avail}, 8'h10);
    forwarded_input(1'b1, 1'b0, 1'b0, 1'b0);
    wr(`LLB_ADDR_PKT_CFG, 8'h35);
    forwarded_input(1'b0, 1'b1, 1'b1, 1'b0);
    forwarded_input(1'b1, 1'b1, 1'b0, 1'b1);
    wr(`LLB_ADDR_SYNC_EN, 8'h01);
    forwarded_input(1'b0, 1'b0, 1'b1, 1'b0);
    wr(`LLB_ADDR_IMMUNITY, 8'h6f);
    @(posedge core_clk);
    #1 chk("immunity off", {7'h0, high_immunity_mode}, 8'h00);
    nrst <= 1'b0;
    cfg_immunity_strap <= 1'b1;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk("immunity strap", {7'h0, high_immunity_mode}, 8'h01);
    wr(`LLB_ADDR_LINK_MODE, 8'h40);
    wr(`LLB_ADDR_IMMUNITY, 8'hef);
    sw(8'h04, 8'h43);
    wr(`LLB_ADDR_LOCAL_ACK, 8'h00);
    repeat (12) @(posedge core_clk);
    #1 chk("him path", {5'h00, high_immunity_mode, local_ack_enable, forward_link_up}, 8'h04);
    test_done;
  end
endmodule
